/* File: design/wts_sequencer.sv */
// Trigger sequencer for waveform playback, with its sample FIFO.
// Assumes trig_ext_in is asynchronous, trig_int_in and all bus signals are mclk synchronous.
//
// How it works
// - External trigger used only when enabled; other settings act only while enabled.
// - Trigger settings apply only while a pattern is selected for playback.
// - Source selector picks external input or internal optional trigger.
// - Mode picks one-time start trigger or per-burst frame trigger.
// - Edge setting picks rising or falling edge detection.
// - Programmable delay in samples, also reported converted into nanoseconds.
// - Changing mode or delay restarts pattern and waits for a fresh trigger.
// - Start mode begins output on first trigger edge after selection.
// - Start mode ignores later trigger edges until restarted.
// - Zero delay starts output exactly one frame period after the edge.
// - Frame period is slot length plus gap length.
// - Gap is zero for continuous patterns, frame minus slot or zero for bursts.
// - Frame mode plays one burst per accepted edge with same latency.
// - Frame mode drops triggers closer than frame period minus mask count.
// - Positive delay lengthens the masking period by the delay.
// - Mask count clamped to 28 divided by interpolation ratio.
// - Interpolation ratio is power of two above 8 giving 80 to 160 MHz.
//
// Implementation choices: the register offsets and strobed register access.
`timescale 1ns/10ps

// ******************************************************************
// Sample FIFO
// ******************************************************************
module wts_fifo #(
    parameter int W = wts_pkg::SAMPLE_W,
    parameter int DEPTH = wts_pkg::FIFO_DEPTH
) (
    input wire logic mclk,
    input wire logic rst,
    input wire logic clr,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [W-1:0] out_data
);
    import wts_pkg::*;

    localparam int PW = $clog2(DEPTH);
    localparam int CW = $clog2(DEPTH + 1);

    typedef struct packed {
        logic [DEPTH-1:0][W-1:0] mem;
        logic [PW-1:0] wptr;
        logic [PW-1:0] rptr;
        logic [CW-1:0] cnt;
    } wts_fifo_t;

    wts_fifo_t q;
    wts_fifo_t d;
    logic push;
    logic pop;

    // Full and empty come straight from the occupancy count.
    assign in_ready = (q.cnt != CW'(DEPTH));
    assign out_valid = (q.cnt != '0);
    assign out_data = q.mem[q.rptr];
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;

    // Pointers advance on accepted transfers; a flush drops all stored samples.
    always_comb
    begin
        d = q;
        if (push)
        begin
            d.mem[q.wptr] = in_data;
            d.wptr = PW'(q.wptr + 1'b1);
        end
        if (pop)
        begin
            d.rptr = PW'(q.rptr + 1'b1);
        end
        d.cnt = CW'(q.cnt + CW'(push) - CW'(pop));
        if (clr)
        begin
            d.wptr = '0;
            d.rptr = '0;
            d.cnt = '0;
        end
    end

    // State register.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end
endmodule // wts_fifo

// ******************************************************************
// Trigger sequencer top
// ******************************************************************
module wts_sequencer (
    input wire logic mclk,
    input wire logic rst,
    input wire wts_pkg::wts_bus_req_t bus,
    output logic [wts_pkg::DATA_W-1:0] rdata,
    input wire logic trig_ext_in,
    input wire logic trig_int_in,
    input wire logic in_valid,
    output logic in_ready,
    input wire logic [wts_pkg::SAMPLE_W-1:0] in_data,
    output logic out_valid,
    input wire logic out_ready,
    output logic [wts_pkg::SAMPLE_W-1:0] out_data,
    output logic pattern_restart,
    output logic playing
);
    import wts_pkg::*;

    typedef struct packed {
        wts_cfg_t cfg;
        logic [23:0] delay;
        logic [23:0] slot_len;
        logic [23:0] frame_len;
        logic [31:0] fs_hz;
        logic [31:0] rdata;
        logic [15:0] drops;
        logic sync1;
        logic sync2;
        logic trig_prev;
        wts_state_t st;
        logic [CNT_W-1:0] lat_cnt;
        logic [1:0] slot_busy;
        logic [1:0][CNT_W-1:0] slot_cnt;
        logic [CNT_W-1:0] burst_cnt;
        logic [CNT_W-1:0] since;
        logic seen;
        logic restart;
    } wts_core_t;

    wts_core_t q;
    wts_core_t d;
    logic gate;
    logic fifo_valid;

    // ******************************************************************
    // Helper functions
    // ******************************************************************

    // Exponent of the interpolation ratio; zero when no ratio fits the octave.
    function automatic logic [4:0] intp_exp(input logic [31:0] fs);
        logic [63:0] prod;
        logic [4:0] e;
        e = '0;
        for (int n = 31; n > INTP_EXP_ABOVE; n--)
        begin
            prod = 64'(fs) << n;
            if (prod > INTP_LOW_HZ && prod <= INTP_HIGH_HZ)
            begin
                e = 5'(n);
            end
        end
        return e;
    endfunction

    // Countdown load so that the event lands exactly p cycles after the edge.
    function automatic logic [CNT_W-1:0] lat_load(input logic [CNT_W-1:0] p);
        return (p > CNT_W'(1)) ? CNT_W'(p - 1'b1) : CNT_W'(1);
    endfunction

    // ******************************************************************
    // Data path
    // ******************************************************************

    // Output is open in free run, after a start trigger, or during a burst.
    assign gate = (q.st == ST_FREE) || (q.st == ST_RUN) || (q.burst_cnt != '0);
    assign playing = gate;
    assign out_valid = fifo_valid & gate;
    assign rdata = q.rdata;
    assign pattern_restart = q.restart;

    // The FIFO holds samples while output is gated and stalls the source once it is full.
    wts_fifo #(
        .W(SAMPLE_W),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .mclk(mclk),
        .rst(rst),
        .clr(q.restart),
        .in_valid(in_valid),
        .in_ready(in_ready),
        .in_data(in_data),
        .out_valid(fifo_valid),
        .out_ready(out_ready & gate),
        .out_data(out_data)
    );

    // ******************************************************************
    // Next state
    // ******************************************************************

    // Registers, trigger detection, masking and the playback sequence.
    always_comb
    begin
        logic trig_lvl;
        logic trig_edge;
        logic restart_req;
        logic arm;
        logic accept;
        logic started;
        logic [CNT_W-1:0] gap;
        logic [CNT_W-1:0] period;
        logic [CNT_W-1:0] period_eff;
        logic [CNT_W-1:0] mask_n;
        logic [CNT_W-1:0] nmax;
        logic [CNT_W-1:0] thr;
        logic [4:0] exp_v;
        logic [31:0] status;
        trig_lvl = 1'b0;
        trig_edge = 1'b0;
        restart_req = 1'b0;
        arm = 1'b0;
        accept = 1'b0;
        started = 1'b0;
        gap = '0;
        period = '0;
        period_eff = '0;
        mask_n = '0;
        nmax = '0;
        thr = '0;
        exp_v = '0;
        status = '0;
        d = q;
        d.restart = 1'b0;

        // The first stage feeds only the second stage.
        d.sync1 = trig_ext_in;
        d.sync2 = q.sync1;
        trig_lvl = q.cfg.src_int ? trig_int_in : q.sync2;
        d.trig_prev = trig_lvl;
        trig_edge = q.cfg.fall_edge ? (q.trig_prev & ~trig_lvl) : (~q.trig_prev & trig_lvl);

        // Frame geometry; all figures but the ratio exponent are sample counts.
        if (q.cfg.burst && (q.frame_len > q.slot_len))
        begin
            gap = CNT_W'(q.frame_len - q.slot_len);
        end
        period = CNT_W'(q.slot_len) + gap;
        period_eff = period + CNT_W'(q.delay);
        exp_v = intp_exp(q.fs_hz);
        nmax = (exp_v == '0) ? '0 : CNT_W'(MASK_CEIL_NUM >> exp_v);
        mask_n = (gap != '0) ? CNT_W'(gap - 1'b1) : '0;
        if (mask_n > nmax)
        begin
            mask_n = nmax;
        end
        thr = (period_eff > mask_n) ? CNT_W'(period_eff - mask_n) : '0;

        // Register writes; a mode or delay change asks for a restart.
        if (bus.wr)
        begin
            unique case (bus.addr)
                OFF_CTRL:
                begin
                    d.cfg.en = bus.wdata[CTRL_EN_BIT];
                    d.cfg.src_int = bus.wdata[CTRL_SRC_BIT];
                    d.cfg.frame_mode = bus.wdata[CTRL_MODE_BIT];
                    d.cfg.fall_edge = bus.wdata[CTRL_EDGE_BIT];
                    d.cfg.pat_sel = bus.wdata[CTRL_PAT_BIT];
                    d.cfg.burst = bus.wdata[CTRL_BURST_BIT];
                    restart_req = bus.wdata[CTRL_RESTART_BIT] ||
                        (bus.wdata[CTRL_MODE_BIT] != q.cfg.frame_mode);
                end
                OFF_DELAY:
                begin
                    d.delay = bus.wdata[23:0];
                    restart_req = (bus.wdata[23:0] != q.delay);
                end
                OFF_SLOT: d.slot_len = bus.wdata[23:0];
                OFF_FRAME: d.frame_len = bus.wdata[23:0];
                OFF_FS: d.fs_hz = bus.wdata;
                default: ;
            endcase
        end

        // Spacing counter since the last accepted frame trigger, saturating.
        if (q.since != '1)
        begin
            d.since = CNT_W'(q.since + 1'b1);
        end
        if (q.burst_cnt != '0)
        begin
            d.burst_cnt = CNT_W'(q.burst_cnt - 1'b1);
        end

        // Pending frame triggers; each opens a burst when its latency ends.
        for (int i = 0; i < 2; i++)
        begin
            if (q.slot_busy[i])
            begin
                if (q.slot_cnt[i] <= CNT_W'(1))
                begin
                    d.slot_busy[i] = 1'b0;
                    d.burst_cnt = CNT_W'(q.slot_len);
                end
                else
                begin
                    d.slot_cnt[i] = CNT_W'(q.slot_cnt[i] - 1'b1);
                end
            end
        end

        // Playback sequence.
        unique case (q.st)
            ST_IDLE, ST_FREE: ;
            ST_WAIT, ST_FRAME:
            begin
                if (q.cfg.frame_mode)
                begin
                    d.st = ST_FRAME;
                    if (trig_edge)
                    begin
                        // Too-close or overflowing triggers are counted and dropped.
                        accept = !q.seen || (q.since >= thr);
                        if (accept && !q.slot_busy[0])
                        begin
                            d.slot_busy[0] = 1'b1;
                            d.slot_cnt[0] = lat_load(period_eff);
                            started = 1'b1;
                        end
                        else if (accept && !q.slot_busy[1])
                        begin
                            d.slot_busy[1] = 1'b1;
                            d.slot_cnt[1] = lat_load(period_eff);
                            started = 1'b1;
                        end
                        if (started)
                        begin
                            d.since = CNT_W'(1);
                            d.seen = 1'b1;
                            if (period_eff <= CNT_W'(1))
                            begin
                                d.slot_busy = q.slot_busy;
                                d.burst_cnt = CNT_W'(q.slot_len);
                            end
                        end
                        else
                        begin
                            d.drops = 16'(q.drops + 1'b1);
                        end
                    end
                end
                else if (trig_edge)
                begin
                    // Start mode takes the first edge only.
                    d.lat_cnt = lat_load(period_eff);
                    d.st = (period_eff <= CNT_W'(1)) ? ST_RUN : ST_LATENCY;
                end
            end
            ST_LATENCY:
            begin
                if (q.lat_cnt <= CNT_W'(1))
                begin
                    d.st = ST_RUN;
                end
                else
                begin
                    d.lat_cnt = CNT_W'(q.lat_cnt - 1'b1);
                end
            end
            ST_RUN: ;
        endcase

        // Selection and enable override the sequence; arming clears all pending work.
        arm = restart_req || (q.st == ST_IDLE) || (q.st == ST_FREE);
        if (!d.cfg.pat_sel)
        begin
            d.st = ST_IDLE;
            d.slot_busy = '0;
            d.burst_cnt = '0;
        end
        else if (!d.cfg.en)
        begin
            d.st = ST_FREE;
            d.slot_busy = '0;
            d.burst_cnt = '0;
        end
        else if (arm)
        begin
            d.st = ST_WAIT;
            d.slot_busy = '0;
            d.burst_cnt = '0;
            d.lat_cnt = '0;
            d.since = '0;
            d.seen = 1'b0;
            d.drops = '0;
            d.restart = 1'b1;
        end

        // Read data stand for the one cycle after the strobe.
        status[STATUS_ST_LSB +: 3] = q.st;
        status[STATUS_PLAY_BIT] = gate;
        status[STATUS_BUSY_LSB +: 2] = q.slot_busy;
        status[STATUS_EXP_LSB +: 5] = exp_v;
        d.rdata = '0;
        if (bus.rd)
        begin
            unique case (bus.addr)
                OFF_CTRL: d.rdata = {26'h0, q.cfg};
                OFF_DELAY: d.rdata = {8'h00, q.delay};
                OFF_SLOT: d.rdata = {8'h00, q.slot_len};
                OFF_FRAME: d.rdata = {8'h00, q.frame_len};
                OFF_FS: d.rdata = q.fs_hz;
                OFF_STATUS: d.rdata = status;
                OFF_DTIME: d.rdata = 32'(32'(q.delay) * 32'(CLK_PERIOD_NS));
                OFF_MASK: d.rdata = 32'(mask_n);
                OFF_PERIOD: d.rdata = 32'(period_eff);
                OFF_DROPS: d.rdata = {16'h0000, q.drops};
                default: d.rdata = '0;
            endcase
        end
    end

    // ******************************************************************
    // State register
    // ******************************************************************

    // Synchronous reset; configuration to named constants, all else to zero.
    always_ff @(posedge mclk)
    begin
        if (rst)
        begin
            q <= '0;
            q.cfg <= CFG_RST;
            q.delay <= DELAY_RST;
            q.slot_len <= SLOT_RST;
            q.frame_len <= FRAME_RST;
            q.fs_hz <= FS_RST;
            q.st <= ST_IDLE;
        end
        else
        begin
            q <= d;
        end
    end
endmodule // wts_sequencer

/* File: design/wts_pkg.sv */
// Shared constants, register map and carrier types of the waveform trigger sequencer.
// Assumes a single 25 MHz clock in which one clock cycle stands for one sample.
package wts_pkg;

    // ******************************************************************
    // Widths and sizes
    // ******************************************************************
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam int CNT_W = 26;
    localparam int SAMPLE_W = 32;
    localparam int FIFO_DEPTH = 16;

    // ******************************************************************
    // Register byte offsets
    // ******************************************************************
    localparam logic [7:0] OFF_CTRL = 8'h00;
    localparam logic [7:0] OFF_DELAY = 8'h04;
    localparam logic [7:0] OFF_SLOT = 8'h08;
    localparam logic [7:0] OFF_FRAME = 8'h0c;
    localparam logic [7:0] OFF_FS = 8'h10;
    localparam logic [7:0] OFF_STATUS = 8'h14;
    localparam logic [7:0] OFF_DTIME = 8'h18;
    localparam logic [7:0] OFF_MASK = 8'h1c;
    localparam logic [7:0] OFF_PERIOD = 8'h20;
    localparam logic [7:0] OFF_DROPS = 8'h24;

    // ******************************************************************
    // Field positions
    // ******************************************************************
    localparam int CTRL_EN_BIT = 0;
    localparam int CTRL_SRC_BIT = 1;
    localparam int CTRL_MODE_BIT = 2;
    localparam int CTRL_EDGE_BIT = 3;
    localparam int CTRL_PAT_BIT = 4;
    localparam int CTRL_BURST_BIT = 5;
    localparam int CTRL_RESTART_BIT = 6;
    localparam int STATUS_ST_LSB = 0;
    localparam int STATUS_PLAY_BIT = 4;
    localparam int STATUS_BUSY_LSB = 8;
    localparam int STATUS_EXP_LSB = 16;

    // ******************************************************************
    // Reset values and timing
    // ******************************************************************
    localparam logic [23:0] DELAY_RST = 24'h000000;
    localparam logic [23:0] SLOT_RST = 24'h000000;
    localparam logic [23:0] FRAME_RST = 24'h000000;
    localparam logic [31:0] FS_RST = 32'h00000000;
    localparam int CLK_PERIOD_NS = 40;
    localparam logic [63:0] INTP_LOW_HZ = 64'd80_000_000;
    localparam logic [63:0] INTP_HIGH_HZ = 64'd160_000_000;
    localparam int INTP_EXP_ABOVE = 3;
    localparam int MASK_CEIL_NUM = 28;

    // ******************************************************************
    // Carrier types
    // ******************************************************************
    typedef struct packed {
        logic wr;
        logic rd;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] wdata;
    } wts_bus_req_t;

    typedef struct packed {
        logic burst;
        logic pat_sel;
        logic fall_edge;
        logic frame_mode;
        logic src_int;
        logic en;
    } wts_cfg_t;

    localparam wts_cfg_t CFG_RST = 6'h00;

    typedef enum logic [2:0] {
        ST_IDLE,
        ST_FREE,
        ST_WAIT,
        ST_LATENCY,
        ST_RUN,
        ST_FRAME
    } wts_state_t;

endpackage

/* File: test/wts_sequencer_monitor.sv */
// Concurrent checks on the trigger sequencer ports.
// Assumes a bind to wts_sequencer and a synchronous active-high reset.
`timescale 1ns/10ps
module wts_sequencer_monitor (
    input wire logic mclk,
    input wire logic rst,
    input wire wts_pkg::wts_bus_req_t bus,
    input wire logic [wts_pkg::DATA_W-1:0] rdata,
    input wire logic in_ready,
    input wire logic out_valid,
    input wire logic out_ready,
    input wire logic [wts_pkg::SAMPLE_W-1:0] out_data,
    input wire logic pattern_restart,
    input wire logic playing
);
    import wts_pkg::*;
    // ********************
    // Port properties
    // ********************
    logic [5:0] ctrl_q;
    logic live;
    default clocking @(posedge mclk); endclocking
    default disable iff (rst);
    // Shadow of the control word, so each check knows mode and enables.
    always_ff @(posedge mclk)
    begin
        if (rst)
            ctrl_q <= 6'h00;
        else if (bus.wr && bus.addr == OFF_CTRL)
            ctrl_q <= bus.wdata[5:0];
    end
    // Enabled with a pattern selected: triggers steer the gate.
    assign live = ctrl_q[CTRL_EN_BIT] && ctrl_q[CTRL_PAT_BIT];
    // Writes are excluded, as state reacts to them at once.
    a_rdata_idle: assert property (!$past(bus.rd) |-> rdata == '0)
        else $error("read data outside its answer cycle");
    a_restart_pulse: assert property (pattern_restart |=> !pattern_restart)
        else $error("restart pulse longer than one cycle");
    a_restart_gate: assert property (pattern_restart |-> !playing)
        else $error("gate open while rearming");
    a_flush_ready: assert property (pattern_restart |=> in_ready)
        else $error("buffer not flushed by restart");
    a_out_gated: assert property (out_valid |-> playing)
        else $error("sample offered with gate closed");
    a_hold_data: assert property (out_valid && !out_ready ##1 out_valid |-> $stable(out_data))
        else $error("stalled sample changed");
    a_start_holds: assert property (playing && live && !ctrl_q[CTRL_MODE_BIT] && !bus.wr
        |=> playing)
        else $error("start mode output stopped");
    a_no_pattern: assert property (!ctrl_q[CTRL_PAT_BIT] && !ctrl_q[CTRL_MODE_BIT] && !bus.wr
        |=> !playing)
        else $error("output without a pattern");
    a_free_run: assert property (ctrl_q[CTRL_PAT_BIT] && !ctrl_q[CTRL_EN_BIT] && !bus.wr
        |=> playing)
        else $error("disabled trigger did not free run");
    c_play: cover property (live && $rose(playing));
    c_arm: cover property (pattern_restart);
    c_take: cover property (out_valid && out_ready);
endmodule // wts_sequencer_monitor

bind wts_sequencer wts_sequencer_monitor u_mon (.mclk, .rst, .bus, .rdata, .in_ready,
    .out_valid, .out_ready, .out_data, .pattern_restart, .playing);

/* File: test/wts_trig_source.sv */
// Model of the outside system that drives the external trigger pin.
// Assumes the caller starts each pulse just after a rising edge of mclk.
`timescale 1ns/10ps
module wts_trig_source (
    output logic trig
);
    // ********************
    // Trigger pin
    // ********************
    // The pin idles low and moves at a phase unrelated to mclk.
    initial trig = 1'b0;
    // High and low phases never go below 40 ns, so no edge is too narrow.
    task automatic pulse(input int ph, input int hi);
        #(ph) trig = 1'b1;
        #((hi < 40) ? 40 : hi) trig = 1'b0;
        #40;
    endtask
endmodule // wts_trig_source

/* File: test/test_wts_sequencer.sv */
// Self-checking bench of the trigger sequencer.
// Assumes the monitor binds itself and the trigger source model is compiled.
`timescale 1ns/10ps
module test_wts_sequencer;
    import wts_pkg::*;
    // ********************
    // Bench
    // ********************
    logic mclk;
    logic rst;
    wts_bus_req_t bus;
    logic [DATA_W-1:0] rdata;
    logic trig_ext_in;
    logic trig_int_in;
    logic in_valid;
    logic in_ready;
    logic [SAMPLE_W-1:0] in_data;
    logic out_valid;
    logic out_ready;
    logic [SAMPLE_W-1:0] out_data;
    logic pattern_restart;
    logic playing;
    int n_fail = 0;
    int n_checks = 0;
    int cyc = 0;
    int s, f, d, fs, b, lg, p, k;
    logic [31:0] v, seen, ex;
    logic [31:0] q[$];

    wts_sequencer u_dut (.mclk, .rst, .bus, .rdata, .trig_ext_in, .trig_int_in, .in_valid,
        .in_ready, .in_data, .out_valid, .out_ready, .out_data, .pattern_restart, .playing);
    wts_trig_source u_src (.trig(trig_ext_in));

    // Clock of 40 ns.
    initial
    begin
        mclk = 1'b0;
        forever #20 mclk = ~mclk;
    end

    // Cuts a hang short; the run needs well under a thousand cycles.
    always @(posedge mclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            n_fail++;
            tally_and_finish();
        end
    end

    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", n_checks, n_fail);
        if (n_fail == 0 && n_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e)
        begin
            n_fail++;
            $display("Error %s expected %h seen %h", n, e, g);
        end
    endtask

    // Bus cycles leave a gap cycle, so no strobe is driven twice in one step.
    task automatic wr(input logic [7:0] a, input logic [31:0] dat);
        @(posedge mclk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: dat};
        @(posedge mclk);
        bus <= '0;
    endtask

    task automatic rd(input logic [7:0] a, output logic [31:0] r);
        @(posedge mclk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: '0};
        @(posedge mclk);
        bus <= '0;
        #1 r = rdata;
    endtask

    task automatic push();
        logic [31:0] w;
        w = $urandom;
        @(posedge mclk);
        in_valid <= 1'b1;
        in_data <= w;
        #1;
        if (in_ready === 1'b1)
            q.push_back(w);
        @(posedge mclk);
        in_valid <= 1'b0;
    endtask

    // The far side stalls at random while the buffer drains.
    task automatic drain();
        int n;
        n = 0;
        while (q.size() > 0 && n < 300)
        begin
            @(posedge mclk);
            out_ready <= 1'($urandom_range(1));
            n++;
            #1;
            if (out_valid === 1'b1 && out_ready === 1'b1)
                chk("sample", q.pop_front(), out_data);
        end
        chk("drained", 0, q.size());
    endtask

    function automatic int f_exp(input int r);
        logic [63:0] t;
        for (int n = INTP_EXP_ABOVE + 1; n < 32; n++)
        begin
            t = 64'(r) << n;
            if (t > INTP_LOW_HZ && t <= INTP_HIGH_HZ)
                return n;
        end
        return 0;
    endfunction

    function automatic int f_mask(input int g, input int e);
        int n, c;
        n = (g > 0) ? g - 1 : 0;
        c = (e > 0) ? (MASK_CEIL_NUM >> e) : 0;
        return (n > c) ? c : n;
    endfunction

    // Main sequence.
    initial
    begin
        bus = '0;
        rst = 1'b1;
        trig_int_in = 1'b0;
        in_valid = 1'b0;
        in_data = '0;
        out_ready = 1'b0;
        void'($urandom(32'hd771));
        repeat (5) @(posedge mclk);
        rst <= 1'b0;
        wr(8'h40, $urandom);
        wr(OFF_DTIME, $urandom);
        for (int a = 0; a <= 'h40; a += 4)
        begin
            rd(8'(a), v);
            chk("reset value", 0, v);
        end
        repeat (4)
        begin
            s = $urandom_range(300);
            f = $urandom_range(300);
            d = $urandom_range(1000);
            fs = $urandom_range(20_000_000, 1000);
            b = $urandom_range(1);
            lg = (b == 1 && f > s) ? f - s : 0;
            wr(OFF_SLOT, s);
            wr(OFF_FRAME, f);
            wr(OFF_DELAY, d);
            wr(OFF_FS, fs);
            wr(OFF_CTRL, b << CTRL_BURST_BIT);
            rd(OFF_DTIME, v);
            chk("delay time", d * CLK_PERIOD_NS, v);
            rd(OFF_PERIOD, v);
            chk("period", s + lg + d, v);
            rd(OFF_MASK, v);
            chk("mask", f_mask(lg, f_exp(fs)), v);
            rd(OFF_STATUS, v);
            chk("ratio", f_exp(fs), v[20:16]);
        end
        wr(OFF_SLOT, 4);
        wr(OFF_FRAME, 8);
        wr(OFF_DELAY, 0);
        wr(OFF_CTRL, 32'h13);
        #1 chk("arm", 1, pattern_restart);
        repeat (20) push();
        chk("accepted", 16, q.size());
        chk("full", 0, in_ready);
        @(posedge mclk);
        trig_int_in <= 1'b1;
        repeat (3) @(posedge mclk);
        #1 chk("gate early", 0, playing);
        @(posedge mclk);
        #1 chk("gate open", 1, playing);
        drain();
        @(posedge mclk);
        trig_int_in <= 1'b0;
        @(posedge mclk);
        trig_int_in <= 1'b1;
        rd(OFF_STATUS, v);
        chk("still running", 4, v[2:0]);
        wr(OFF_DELAY, 0);
        #1 chk("same delay", 0, pattern_restart);
        wr(OFF_DELAY, 2);
        #1 chk("delay arm", 1, pattern_restart);
        wr(OFF_FS, 10_000_000);
        wr(OFF_CTRL, 32'h3f);
        #1 chk("mode arm", 1, pattern_restart);
        p = 4 + (8 - 4) + 2;
        rd(OFF_MASK, v);
        chk("mask clamp", f_mask(8 - 4, f_exp(10_000_000)), v);
        rd(OFF_PERIOD, v);
        chk("frame period", p, v);
        // Falls at cycles 0, 5 and 9; the one at 5 comes too soon.
        for (int i = 0; i < 32; i++)
        begin
            @(posedge mclk);
            trig_int_in <= ~(i inside {[0:2], [5:6], [9:10]});
            #1 seen[i] = playing;
            ex[i] = (i >= p && i < p + 4) || (i >= p + 9 && i < p + 13);
        end
        chk("bursts", ex, seen);
        rd(OFF_DROPS, v);
        chk("drops", 1, v);
        wr(OFF_CTRL, 32'h11);
        #1 chk("source arm", 1, pattern_restart);
        for (int i = 0; i < 12; i++)
        begin
            @(posedge mclk);
            trig_int_in <= i[0];
            #1 chk("other source", 0, playing);
        end
        @(posedge mclk);
        fork
            u_src.pulse($urandom_range(35, 5), 80);
        join_none
        k = 0;
        while (playing !== 1'b1 && k < 40)
        begin
            @(posedge mclk);
            k++;
            #1;
        end
        chk("external latency", 6 + 2, k);
        wr(OFF_CTRL, 32'h51);
        #1 chk("rearm", 1, pattern_restart);
        wr(OFF_CTRL, 32'h10);
        rd(OFF_STATUS, v);
        chk("free run", 32'h11, v[4:0]);
        wr(OFF_CTRL, 32'h00);
        rd(OFF_STATUS, v);
        chk("no pattern", 0, v[4:0]);
        tally_and_finish();
    end
endmodule // test_wts_sequencer
